// ===== rtl/snpb_param_bank.sv
// network setting and unit conversion parameter bank of the drive
// Summary of operation
// - attribute selector digit, 0 newer, 1 older
// - listed objects mappable per selected attribute set
// - cycle setting copied into both cycle-time objects
// - setting zero loads 250000 ns
// - decode codes 00, 04 to 0A to cycles
// - unsupported cycle code raises parameter error alarm
// - counter reaching threshold raises receive alarm
// - threshold zero disables receive error detection
// - missed update at sync adds three
// - good update at sync subtracts one, floor zero
// - after alarm counter holds at threshold
// - threshold mirrored as sync error limit object
// - warning mask applied to warning details
// - error mask applied to error details
// - speed numerator 1 to 1024, command units only
// - speed denominator 1 to 256, command units only
// - accel numerator 1 to 1024, command units only
// - unit selection picks native or command units
`timescale 1ns/1ps
`include "snpb_regs.svh"

module snpb_param_bank (
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      prmWe,
    input  wire logic [3:0]                prmAddr,
    input  wire logic [31:0]               prmWdata,
    output logic [31:0]                    prmRdata,
    input  wire logic                      sync0,
    input  wire logic                      pdoUpdated,
    input  wire logic                      alarmClear,
    input  wire logic                      unitSelection,
    input  wire snpb_pkg::snpb_map_query_t mapQuery,
    output snpb_pkg::snpb_map_answer_t     mapAnswer,
    output logic [31:0]                    cycleTimeOut,
    output logic [31:0]                    cycleTimeIn,
    output logic                           parameterErrorAlarm,
    output logic                           networkReceiveDataErrorAlarm,
    output logic [15:0]                    syncErrLimit,
    output logic [31:0]                    warnMaskObj,
    output logic [31:0]                    errMaskObj,
    input  wire snpb_pkg::snpb_detail_t    warnDetail,
    input  wire snpb_pkg::snpb_detail_t    errDetail,
    output snpb_pkg::snpb_detail_t         warnDetailMasked,
    output snpb_pkg::snpb_detail_t         errDetailMasked,
    input  wire logic [31:0]               cmdSpeed,
    input  wire logic [31:0]               cmdAccel,
    output logic [31:0]                    speedInternal,
    output logic [31:0]                    accelInternal
);
    import snpb_pkg::*;

    logic [31:0] commModeR;
    logic [31:0] cycleInitR;
    logic [15:0] rxErrThrR;
    logic [31:0] warnMaskR;
    logic [31:0] errMaskR;
    logic [15:0] spdNumR;
    logic [15:0] spdDenR;
    logic [15:0] accNumR;
    logic [16:0] errCnt_r;
    logic [16:0] errCnt_nxt;
    logic        alarm_nxt;
    logic        sync0M;
    logic        sync0S;
    logic        sync0D;
    logic        updM;
    logic        updS;
    logic        syncEvt;
    logic        attrOld;
    logic [32:0] cycDec;
    logic [42:0] spdProd;
    logic [42:0] accProd;
    logic [16:0] thrWide;

    // {valid, nanoseconds} for a cycle code; upper bits must be clear
    function automatic logic [32:0] cycleDecode(input logic [31:0] v);
        logic [32:0] r;
        r = {1'b0, `SNPB_NS_250US};
        if (v[31:8] == 24'h00_0000) begin
            case (v[7:0])
                `SNPB_CYC_AUTO:  r = {1'b1, `SNPB_NS_250US};
                `SNPB_CYC_125US: r = {1'b1, `SNPB_NS_125US};
                `SNPB_CYC_250US: r = {1'b1, `SNPB_NS_250US};
                `SNPB_CYC_500US: r = {1'b1, `SNPB_NS_500US};
                `SNPB_CYC_1MS:   r = {1'b1, `SNPB_NS_1MS};
                `SNPB_CYC_2MS:   r = {1'b1, `SNPB_NS_2MS};
                `SNPB_CYC_4MS:   r = {1'b1, `SNPB_NS_4MS};
                `SNPB_CYC_8MS:   r = {1'b1, `SNPB_NS_8MS};
                default:         r = {1'b0, `SNPB_NS_250US};
            endcase
        end
        return r;
    endfunction

    function automatic logic wr(input logic [3:0] a);
        return prmWe && (prmAddr == a);
    endfunction

    // parameter writes; out-of-range values are dropped, old value stays
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            commModeR  <= `SNPB_RST_COMM_MODE;
            cycleInitR <= `SNPB_RST_CYCLE_INIT;
            rxErrThrR  <= `SNPB_RST_RX_ERR_THR;
            warnMaskR  <= `SNPB_RST_MASK;
            errMaskR   <= `SNPB_RST_MASK;
            spdNumR    <= `SNPB_RST_GEAR;
            spdDenR    <= `SNPB_RST_GEAR;
            accNumR    <= `SNPB_RST_GEAR;
        end else begin
            if (wr(`SNPB_ADDR_COMM_MODE)) begin
                commModeR <= prmWdata;
            end
            if (wr(`SNPB_ADDR_CYCLE_INIT)) begin
                cycleInitR <= prmWdata;
            end
            if (wr(`SNPB_ADDR_RX_ERR_THR) && prmWdata <= {16'h0000, `SNPB_THR_MAX}) begin
                rxErrThrR <= prmWdata[15:0];
            end
            if (wr(`SNPB_ADDR_WARN_MASK) && prmWdata <= `SNPB_RST_MASK) begin
                warnMaskR <= prmWdata;
            end
            if (wr(`SNPB_ADDR_ERR_MASK) && prmWdata <= `SNPB_RST_MASK) begin
                errMaskR <= prmWdata;
            end
            if (wr(`SNPB_ADDR_SPD_NUM) && prmWdata != 32'h0000_0000
                && prmWdata <= {16'h0000, `SNPB_NUM_MAX}) begin
                spdNumR <= prmWdata[15:0];
            end
            if (wr(`SNPB_ADDR_SPD_DEN) && prmWdata != 32'h0000_0000
                && prmWdata <= {16'h0000, `SNPB_DEN_MAX}) begin
                spdDenR <= prmWdata[15:0];
            end
            if (wr(`SNPB_ADDR_ACC_NUM) && prmWdata != 32'h0000_0000
                && prmWdata <= {16'h0000, `SNPB_NUM_MAX}) begin
                accNumR <= prmWdata[15:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prmRdata <= 32'h0000_0000;
        end else begin
            case (prmAddr)
                `SNPB_ADDR_COMM_MODE:  prmRdata <= commModeR;
                `SNPB_ADDR_CYCLE_INIT: prmRdata <= cycleInitR;
                `SNPB_ADDR_RX_ERR_THR: prmRdata <= {16'h0000, rxErrThrR};
                `SNPB_ADDR_WARN_MASK:  prmRdata <= warnMaskR;
                `SNPB_ADDR_ERR_MASK:   prmRdata <= errMaskR;
                `SNPB_ADDR_SPD_NUM:    prmRdata <= {16'h0000, spdNumR};
                `SNPB_ADDR_SPD_DEN:    prmRdata <= {16'h0000, spdDenR};
                `SNPB_ADDR_ACC_NUM:    prmRdata <= {16'h0000, accNumR};
                `SNPB_ADDR_STATUS:     prmRdata <= {13'h0000, parameterErrorAlarm,
                                                    networkReceiveDataErrorAlarm, errCnt_r};
                default:               prmRdata <= 32'h0000_0000;
            endcase
        end
    end

    // pins from the link side are synchronised before use
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync0M <= 1'b0;
            sync0S <= 1'b0;
            sync0D <= 1'b0;
            updM   <= 1'b0;
            updS   <= 1'b0;
        end else begin
            sync0M <= sync0;
            sync0S <= sync0M;
            sync0D <= sync0S;
            updM   <= pdoUpdated;
            updS   <= updM;
        end
    end

    assign syncEvt = sync0S & ~sync0D;
    assign thrWide = {1'b0, rxErrThrR};

    always_comb begin
        errCnt_nxt = errCnt_r;
        alarm_nxt  = networkReceiveDataErrorAlarm;
        if (rxErrThrR == 16'h0000) begin
            errCnt_nxt = 17'h0_0000;
            alarm_nxt  = 1'b0;
        end else if (networkReceiveDataErrorAlarm) begin
            errCnt_nxt = thrWide;
            // a new miss in the clearing cycle keeps the alarm standing
            if (alarmClear && !(syncEvt && !updS)) begin
                alarm_nxt  = 1'b0;
                errCnt_nxt = 17'h0_0000;
            end
        end else if (syncEvt && !updS) begin
            if (errCnt_r + `SNPB_ERR_INC >= thrWide) begin
                errCnt_nxt = thrWide;
                alarm_nxt  = 1'b1;
            end else begin
                errCnt_nxt = errCnt_r + `SNPB_ERR_INC;
            end
        end else if (syncEvt && errCnt_r != 17'h0_0000) begin
            errCnt_nxt = errCnt_r - `SNPB_ERR_DEC;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            errCnt_r                     <= 17'h0_0000;
            networkReceiveDataErrorAlarm <= 1'b0;
        end else begin
            errCnt_r                     <= errCnt_nxt;
            networkReceiveDataErrorAlarm <= alarm_nxt;
        end
    end

    assign cycDec = cycleDecode(cycleInitR);

    // an unsupported code leaves the cycle-time objects at their last good value
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cycleTimeOut        <= `SNPB_NS_250US;
            cycleTimeIn         <= `SNPB_NS_250US;
            parameterErrorAlarm <= 1'b0;
        end else begin
            parameterErrorAlarm <= ~cycDec[32];
            if (cycDec[32]) begin
                cycleTimeOut <= cycDec[31:0];
                cycleTimeIn  <= cycDec[31:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            syncErrLimit     <= `SNPB_RST_RX_ERR_THR;
            warnMaskObj      <= `SNPB_RST_MASK;
            errMaskObj       <= `SNPB_RST_MASK;
            warnDetailMasked <= '0;
            errDetailMasked  <= '0;
        end else begin
            syncErrLimit             <= rxErrThrR;
            warnMaskObj              <= warnMaskR;
            errMaskObj               <= errMaskR;
            warnDetailMasked.active  <= warnDetail.active & warnMaskR;
            warnDetailMasked.latched <= warnDetail.latched & warnMaskR;
            errDetailMasked.active   <= errDetail.active & errMaskR;
            errDetailMasked.latched  <= errDetail.latched & errMaskR;
        end
    end

    assign attrOld = commModeR[`SNPB_SEL_LSB +: 4] == 4'h1;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mapAnswer <= '0;
        end else begin
            mapAnswer <= '0;
            if ((mapQuery.sub == `SNPB_SUB_00 && (mapQuery.index == `SNPB_OBJ_MAX_TORQUE
                 || mapQuery.index == `SNPB_OBJ_HOME_OFFSET
                 || mapQuery.index == `SNPB_OBJ_MAX_SPEED))
                || (mapQuery.index == `SNPB_OBJ_POS_FACTOR
                 && (mapQuery.sub == `SNPB_SUB_01 || mapQuery.sub == `SNPB_SUB_02))) begin
                mapAnswer.listed <= 1'b1;
                mapAnswer.rxOk   <= !attrOld || mapQuery.index == `SNPB_OBJ_MAX_TORQUE;
                mapAnswer.txOk   <= attrOld;
            end
        end
    end

    // accel denominator lives in another group, so accel only scales up
    assign spdProd = {11'h000, cmdSpeed} * {27'h000_0000, spdNumR};
    assign accProd = {11'h000, cmdAccel} * {27'h000_0000, accNumR};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            speedInternal <= 32'h0000_0000;
            accelInternal <= 32'h0000_0000;
        end else if (unitSelection) begin
            speedInternal <= 32'(spdProd / {27'h000_0000, spdDenR});
            accelInternal <= accProd[31:0];
        end else begin
            speedInternal <= cmdSpeed;
            accelInternal <= cmdAccel;
        end
    end

    sequence missAtSync;
        syncEvt && !updS && rxErrThrR != 16'h0000 && !networkReceiveDataErrorAlarm;
    endsequence

    sequence goodAtSync;
        syncEvt && updS && rxErrThrR != 16'h0000 && !networkReceiveDataErrorAlarm;
    endsequence

    thr_zero_off_a: assert property (@(posedge mclk) disable iff (!resetn)
        rxErrThrR == 16'h0000 |=> !networkReceiveDataErrorAlarm && errCnt_r == 17'h0_0000)
        else $error("alarm or count with zero threshold");
    miss_adds_three_a: assert property (@(posedge mclk) disable iff (!resetn)
        missAtSync and (errCnt_r + 17'h0_0003 < thrWide)
        |=> errCnt_r == $past(errCnt_r) + 17'h0_0003)
        else $error("miss did not add three");
    good_sub_one_a: assert property (@(posedge mclk) disable iff (!resetn)
        goodAtSync and (errCnt_r != 17'h0_0000) |=> errCnt_r == $past(errCnt_r) - 17'h0_0001)
        else $error("good update did not subtract one");
    count_floor_a: assert property (@(posedge mclk) disable iff (!resetn)
        goodAtSync and (errCnt_r == 17'h0_0000) |=> errCnt_r == 17'h0_0000)
        else $error("count went below zero");
    alarm_raise_a: assert property (@(posedge mclk) disable iff (!resetn)
        missAtSync and (errCnt_r + 17'h0_0003 >= thrWide) |=> networkReceiveDataErrorAlarm
        && errCnt_r == {1'b0, $past(rxErrThrR)})
        else $error("threshold reached without alarm");
    count_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        networkReceiveDataErrorAlarm && !alarmClear && rxErrThrR != 16'h0000
        |=> networkReceiveDataErrorAlarm && errCnt_r == {1'b0, $past(rxErrThrR)})
        else $error("count left threshold under alarm");
    cycle_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
        cycleInitR == 32'h0000_0000
        |=> cycleTimeOut == `SNPB_NS_250US && cycleTimeIn == `SNPB_NS_250US)
        else $error("zero setting did not give 250000 ns");
    cycle_bad_a: assert property (@(posedge mclk) disable iff (!resetn)
        !cycDec[32] |=> parameterErrorAlarm && $stable(cycleTimeOut))
        else $error("bad cycle code not flagged");
    warn_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
        1'b1 |=> warnDetailMasked.active == ($past(warnDetail.active) & $past(warnMaskR)))
        else $error("warning mask not applied");
    map_attr_a: assert property (@(posedge mclk) disable iff (!resetn)
        mapQuery.index == `SNPB_OBJ_HOME_OFFSET && mapQuery.sub == `SNPB_SUB_00
        |=> mapAnswer.listed && mapAnswer.rxOk == !$past(attrOld)
        && mapAnswer.txOk == $past(attrOld))
        else $error("home offset mapping attribute wrong");
    gear_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
        wr(`SNPB_ADDR_SPD_NUM) && prmWdata == 32'h0000_0000 |=> $stable(spdNumR))
        else $error("zero numerator accepted");
endmodule

// ===== rtl/snpb_pkg.sv
// types shared by the network parameter bank
package snpb_pkg;
    typedef struct packed {
        logic [15:0] index;
        logic [7:0]  sub;
    } snpb_map_query_t;

    typedef struct packed {
        logic listed;
        logic rxOk;
        logic txOk;
    } snpb_map_answer_t;

    typedef struct packed {
        logic [31:0] active;
        logic [31:0] latched;
    } snpb_detail_t;
endpackage

// ===== rtl/snpb_regs.svh
// offsets, reset values, codes and timing constants of the network parameter bank
`ifndef SNPB_REGS_SVH
`define SNPB_REGS_SVH

`define SNPB_ADDR_COMM_MODE    4'h0
`define SNPB_ADDR_CYCLE_INIT   4'h1
`define SNPB_ADDR_RX_ERR_THR   4'h2
`define SNPB_ADDR_WARN_MASK    4'h3
`define SNPB_ADDR_ERR_MASK     4'h4
`define SNPB_ADDR_SPD_NUM      4'h5
`define SNPB_ADDR_SPD_DEN      4'h6
`define SNPB_ADDR_ACC_NUM      4'h7
`define SNPB_ADDR_STATUS       4'h8

`define SNPB_RST_COMM_MODE     32'h0000_0000
`define SNPB_RST_CYCLE_INIT    32'h0000_0000
`define SNPB_RST_RX_ERR_THR    16'h0009
`define SNPB_RST_MASK          32'h0FFF_FFFF
`define SNPB_RST_GEAR          16'h0001

`define SNPB_SEL_LSB           12
`define SNPB_THR_MAX           16'h7FFF
`define SNPB_NUM_MAX           16'h0400
`define SNPB_DEN_MAX           16'h0100
`define SNPB_ERR_INC           17'h0_0003
`define SNPB_ERR_DEC           17'h0_0001

`define SNPB_CYC_AUTO          8'h00
`define SNPB_CYC_125US         8'h04
`define SNPB_CYC_250US         8'h05
`define SNPB_CYC_500US         8'h06
`define SNPB_CYC_1MS           8'h07
`define SNPB_CYC_2MS           8'h08
`define SNPB_CYC_4MS           8'h09
`define SNPB_CYC_8MS           8'h0A
`define SNPB_NS_125US          32'h0001_E848
`define SNPB_NS_250US          32'h0003_D090
`define SNPB_NS_500US          32'h0007_A120
`define SNPB_NS_1MS            32'h000F_4240
`define SNPB_NS_2MS            32'h001E_8480
`define SNPB_NS_4MS            32'h003D_0900
`define SNPB_NS_8MS            32'h007A_1200

`define SNPB_OBJ_MAX_TORQUE    16'h6072
`define SNPB_OBJ_HOME_OFFSET   16'h607C
`define SNPB_OBJ_MAX_SPEED     16'h6080
`define SNPB_OBJ_POS_FACTOR    16'h608F
`define SNPB_SUB_00            8'h00
`define SNPB_SUB_01            8'h01
`define SNPB_SUB_02            8'h02

`endif

// ===== tb/snpb_master_model.sv
// fieldbus master model: sync events with or without fresh receive data
`timescale 1ns/1ps
module snpb_master_model (
    input  wire logic mclk,
    output logic      sync0,
    output logic      pdoUpdated
);
    initial begin
        sync0      = 1'b0;
        pdoUpdated = 1'b0;
    end
    // 3 high and at least 3 low keeps clear of the 2+2 spacing the sampler needs
    task automatic send_event(input logic good, input int lowCycles);
        @(posedge mclk);
        sync0      <= 1'b1;
        pdoUpdated <= good;
        repeat (3) @(posedge mclk);
        sync0      <= 1'b0;
        // flag no longer valid once the pulse ends: show the opposite level
        pdoUpdated <= ~good;
        repeat (lowCycles) @(posedge mclk);
    endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the network parameter bank
`timescale 1ns/1ps
`include "snpb_regs.svh"
module tb_top;
    import snpb_pkg::*;
    logic             mclk;
    logic             resetn;
    logic             prmWe;
    logic [3:0]       prmAddr;
    logic [31:0]      prmWdata;
    logic [31:0]      prmRdata;
    logic             sync0;
    logic             pdoUpdated;
    logic             alarmClear;
    logic             unitSelection;
    snpb_map_query_t  mapQuery;
    snpb_map_answer_t mapAnswer;
    logic [31:0]      cycleTimeOut;
    logic [31:0]      cycleTimeIn;
    logic             parameterErrorAlarm;
    logic             networkReceiveDataErrorAlarm;
    logic [15:0]      syncErrLimit;
    logic [31:0]      warnMaskObj;
    logic [31:0]      errMaskObj;
    snpb_detail_t     warnDetail;
    snpb_detail_t     errDetail;
    snpb_detail_t     warnDetailMasked;
    snpb_detail_t     errDetailMasked;
    logic [31:0]      cmdSpeed;
    logic [31:0]      cmdAccel;
    logic [31:0]      speedInternal;
    logic [31:0]      accelInternal;
    int               n_mismatch;
    int               checked;
    int               cycles;

    snpb_param_bank i_snpb_param_bank (.mclk(mclk), .resetn(resetn), .prmWe(prmWe),
        .prmAddr(prmAddr), .prmWdata(prmWdata), .prmRdata(prmRdata), .sync0(sync0),
        .pdoUpdated(pdoUpdated), .alarmClear(alarmClear), .unitSelection(unitSelection),
        .mapQuery(mapQuery), .mapAnswer(mapAnswer), .cycleTimeOut(cycleTimeOut),
        .cycleTimeIn(cycleTimeIn), .parameterErrorAlarm(parameterErrorAlarm),
        .networkReceiveDataErrorAlarm(networkReceiveDataErrorAlarm),
        .syncErrLimit(syncErrLimit), .warnMaskObj(warnMaskObj), .errMaskObj(errMaskObj),
        .warnDetail(warnDetail), .errDetail(errDetail), .warnDetailMasked(warnDetailMasked),
        .errDetailMasked(errDetailMasked), .cmdSpeed(cmdSpeed), .cmdAccel(cmdAccel),
        .speedInternal(speedInternal), .accelInternal(accelInternal));
    snpb_master_model i_snpb_master_model (.mclk(mclk), .sync0(sync0),
        .pdoUpdated(pdoUpdated));

    always #12.5 mclk = ~mclk;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ceiling well above the few hundred cycles the scenarios take
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        prmWe    <= 1'b1;
        prmAddr  <= a;
        prmWdata <= d;
        @(posedge mclk);
        prmWe    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        prmAddr <= a;
        repeat (3) @(posedge mclk);
        #1 check(n, prmRdata, e);
    endtask

    task automatic t_reset();
        rd(`SNPB_ADDR_COMM_MODE, 32'h0000_0000, "comm mode");
        rd(`SNPB_ADDR_CYCLE_INIT, 32'h0000_0000, "cycle init");
        rd(`SNPB_ADDR_RX_ERR_THR, 32'h0000_0009, "threshold");
        rd(`SNPB_ADDR_WARN_MASK, 32'h0FFF_FFFF, "warn mask");
        rd(`SNPB_ADDR_ERR_MASK, 32'h0FFF_FFFF, "err mask");
        rd(`SNPB_ADDR_SPD_NUM, 32'h0000_0001, "spd num");
        rd(`SNPB_ADDR_SPD_DEN, 32'h0000_0001, "spd den");
        rd(`SNPB_ADDR_ACC_NUM, 32'h0000_0001, "acc num");
        rd(4'hF, 32'h0000_0000, "unmapped");
        check("cycle out", cycleTimeOut, `SNPB_NS_250US);
        check("limit obj", {16'h0000, syncErrLimit}, 32'h0000_0009);
    endtask

    task automatic t_cycle();
        logic [7:0]  codes[8];
        logic [31:0] ns[8];
        logic [31:0] bad[3];
        codes = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
        ns = '{`SNPB_NS_250US, `SNPB_NS_125US, `SNPB_NS_250US, `SNPB_NS_500US,
               `SNPB_NS_1MS, `SNPB_NS_2MS, `SNPB_NS_4MS, `SNPB_NS_8MS};
        bad = '{32'h0000_0003, 32'h0000_000B, 32'h0000_0104};
        for (int i = 7; i >= 0; i--) begin
            wr(`SNPB_ADDR_CYCLE_INIT, {24'h00_0000, codes[i]});
            repeat (3) @(posedge mclk);
            #1 check("cycle out", cycleTimeOut, ns[i]);
            check("cycle in", cycleTimeIn, ns[i]);
            check("param alarm", {31'h0, parameterErrorAlarm}, 32'h0000_0000);
        end
        for (int i = 0; i < 3; i++) begin
            wr(`SNPB_ADDR_CYCLE_INIT, bad[i]);
            repeat (3) @(posedge mclk);
            #1 check("bad alarm", {31'h0, parameterErrorAlarm}, 32'h0000_0001);
            check("kept cycle", cycleTimeIn, `SNPB_NS_250US);
        end
        wr(`SNPB_ADDR_CYCLE_INIT, 32'h0000_0000);
    endtask

    task automatic t_map();
        logic [23:0] objs[6];
        logic [2:0]  e;
        objs = '{24'h6072_00, 24'h607C_00, 24'h6080_00, 24'h608F_01, 24'h608F_02,
                 24'h6081_00};
        for (int s = 0; s < 2; s++) begin
            wr(`SNPB_ADDR_COMM_MODE, s ? 32'h0000_1000 : 32'h0000_0000);
            for (int i = 0; i < 6; i++) begin
                // listed, rx, tx
                e = (i == 5) ? 3'b000 : (s == 0) ? 3'b110 : (i == 0) ? 3'b111 : 3'b101;
                @(posedge mclk);
                mapQuery <= objs[i];
                repeat (2) @(posedge mclk);
                #1 check("map answer", {29'h0, mapAnswer}, {29'h0, e});
            end
        end
    endtask

    task automatic t_sync();
        logic [16:0] cnt;
        logic        alarm;
        logic        good;
        cnt   = 17'h0_0000;
        alarm = 1'b0;
        for (int i = 0; i < 12; i++) begin
            good = (i % 2 == 0);
            i_snpb_master_model.send_event(good, (i % 3 == 0) ? 8 : 3);
            if (!alarm && !good) begin
                cnt   = (cnt + 3 >= 9) ? 17'h0_0009 : cnt + 3;
                alarm = (cnt == 9);
            end else if (!alarm && cnt != 0) begin
                cnt = cnt - 1;
            end
            rd(`SNPB_ADDR_STATUS, {14'h0, alarm, cnt}, "cnt");
            check("rx alarm", {31'h0, networkReceiveDataErrorAlarm}, {31'h0, alarm});
        end
        @(posedge mclk);
        alarmClear <= 1'b1;
        @(posedge mclk);
        alarmClear <= 1'b0;
        rd(`SNPB_ADDR_STATUS, 32'h0000_0000, "cleared");
        wr(`SNPB_ADDR_RX_ERR_THR, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            i_snpb_master_model.send_event(1'b0, 3);
        end
        rd(`SNPB_ADDR_STATUS, 32'h0000_0000, "disabled");
        wr(`SNPB_ADDR_RX_ERR_THR, 32'h0000_8000);
        rd(`SNPB_ADDR_RX_ERR_THR, 32'h0000_0000, "thr refused");
        wr(`SNPB_ADDR_RX_ERR_THR, 32'h0000_7FFF);
        rd(`SNPB_ADDR_RX_ERR_THR, 32'h0000_7FFF, "thr max");
        check("limit obj", {16'h0000, syncErrLimit}, 32'h0000_7FFF);
    endtask

    task automatic t_mask();
        @(posedge mclk);
        warnDetail <= {32'hFFFF_FFFF, 32'h1234_5678};
        errDetail  <= {32'h8765_4321, 32'hFFFF_FFFF};
        wr(`SNPB_ADDR_WARN_MASK, 32'h0000_F0F0);
        wr(`SNPB_ADDR_ERR_MASK, 32'h0AAA_0000);
        wr(`SNPB_ADDR_ERR_MASK, 32'h1000_0000);
        repeat (3) @(posedge mclk);
        #1 check("warn obj", warnMaskObj, 32'h0000_F0F0);
        check("warn act", warnDetailMasked.active, 32'h0000_F0F0);
        check("warn lat", warnDetailMasked.latched, 32'h0000_5070);
        check("err obj", errMaskObj, 32'h0AAA_0000);
        check("err act", errDetailMasked.active, 32'h0220_0000);
        check("err lat", errDetailMasked.latched, 32'h0AAA_0000);
    endtask

    task automatic t_gear();
        @(posedge mclk);
        cmdSpeed <= 32'h0000_03E8;
        cmdAccel <= 32'h0000_0064;
        wr(`SNPB_ADDR_SPD_NUM, 32'h0000_0003);
        wr(`SNPB_ADDR_SPD_NUM, 32'h0000_0000);
        wr(`SNPB_ADDR_SPD_DEN, 32'h0000_0002);
        wr(`SNPB_ADDR_SPD_DEN, 32'h0000_0101);
        wr(`SNPB_ADDR_ACC_NUM, 32'h0000_0005);
        wr(`SNPB_ADDR_ACC_NUM, 32'h0000_0401);
        repeat (3) @(posedge mclk);
        #1 check("native spd", speedInternal, 32'h0000_03E8);
        check("native acc", accelInternal, 32'h0000_0064);
        @(posedge mclk);
        unitSelection <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check("spd scaled", speedInternal, 32'h0000_05DC);
        check("acc scaled", accelInternal, 32'h0000_01F4);
        wr(`SNPB_ADDR_SPD_NUM, 32'h0000_0400);
        wr(`SNPB_ADDR_SPD_DEN, 32'h0000_0100);
        repeat (3) @(posedge mclk);
        #1 check("spd limits", speedInternal, 32'h0000_0FA0);
        @(posedge mclk);
        unitSelection <= 1'b0;
    endtask

    initial begin
        mclk          = 1'b0;
        resetn        = 1'b0;
        prmWe         = 1'b0;
        prmAddr       = 4'h0;
        prmWdata      = 32'h0000_0000;
        alarmClear    = 1'b0;
        unitSelection = 1'b0;
        mapQuery      = 24'h00_0000;
        warnDetail    = 64'h0;
        errDetail     = 64'h0;
        cmdSpeed      = 32'h0000_0000;
        cmdAccel      = 32'h0000_0000;
        n_mismatch    = 0;
        checked       = 0;
        cycles        = 0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_cycle();
        t_map();
        t_sync();
        t_mask();
        t_gear();
        complete_run();
    end
endmodule
